// File: src/cmm_map.svh
// register offsets, field positions, reset values and timing figures of the module management control
// Function
// - Double-density end finishes initialisation within 2000 ms
// - Reset pulses of 10 us or more reset (the code needs 1251 cycles at 125 MHz, one cycle over 10 us)
// - Flag set, pin low within 200 ms
// - Read clears flags; pin released within 500 us
// - Receive loss flag, pin low within 100 ms
// - Set mask stops pin pull within 100 ms
// - Cleared mask restores pin pull within 100 ms
// - Four-lane end fully functional within 2 s
// - Management bus answers within 2 s of power-on
// - Data-not-ready clears, pin low within 2 s
// - Fully functional within 2 s after reset release
// - Power-pin function switch completes within 100 ms
// - Low-power request reaches class 1 within 100 ms
// - Low-power release gives full function within 300 ms
// - Interrupt-pin function switch completes within 100 ms
// - Power bits: 100 ms down, 300 ms up
`ifndef CMM_MAP_SVH
`define CMM_MAP_SVH

// clock rate and times
`define CMM_CLK_MHZ 125
`define CMM_INIT_MAX_MS 2000
`define CMM_RESET_MIN_US 10
`define CMM_WAKE_MAX_MS 300
`define CMM_RESET_MIN_CYC (`CMM_RESET_MIN_US * `CMM_CLK_MHZ)

// register byte offsets
`define CMM_OFF_STATUS 8'h00
`define CMM_OFF_FLAGS 8'h04
`define CMM_OFF_FLAG_CLR 8'h08
`define CMM_OFF_MASK 8'h0c
`define CMM_OFF_IRQ_EN 8'h10
`define CMM_OFF_CTRL 8'h14

// status fields
`define CMM_ST_NOT_READY 0
`define CMM_ST_INIT 1
`define CMM_ST_FUNCTIONAL 2
`define CMM_ST_CLASS_ONE 3
`define CMM_ST_TX_DISABLE 4
`define CMM_ST_RX_LOSS 5
`define CMM_ST_RESET_PIN 6

// control fields
`define CMM_CTRL_OVERRIDE 0
`define CMM_CTRL_SOFT_LP 1
`define CMM_CTRL_PIN_IS_DISABLE 2
`define CMM_CTRL_INT_IS_LOSS 3
`define CMM_CTRL_W 4

// flag positions
`define CMM_FLAG_RX_LOSS 0
`define CMM_FLAG_TX_FAULT 1

// reset values
`define CMM_CTRL_RST 4'h0
`define CMM_MASK_RST 32'h0000_0000
`define CMM_IRQ_EN_RST 32'h0000_0000

`endif

// File: src/cmm_pkg.sv
// types of the module management control
package cmm_pkg;

	typedef enum logic [1:0] {
		CMM_INIT,
		CMM_LOWPWR,
		CMM_WAKING,
		CMM_ACTIVE
	} cmm_state_type;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [31:0] dat;
		logic [3:0] sel;
	} cmm_wb_req_type;

	typedef struct packed {
		logic management_init_state;
		logic fullyFunctional;
		logic powerClassOne;
		logic transmit_disable;
		logic dataNotReady;
	} cmm_status_type;

endpackage

// File: src/cmm_ctrl.sv
// management control and status of a pluggable module end
`include "cmm_map.svh"

module cmm_ctrl #(
	parameter int FLAG_W = 8,
	parameter int INIT_CYCLES = `CMM_INIT_MAX_MS * 1000 * `CMM_CLK_MHZ,
	parameter int WAKE_CYCLES = `CMM_WAKE_MAX_MS * 1000 * `CMM_CLK_MHZ
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// wishbone slave
	input cmm_pkg::cmm_wb_req_type wbReq,
	output logic wbAck,
	output logic [31:0] wbDatRd,
	// host pins
	input wire logic module_reset_n,
	input wire logic dual_power_or_disable_pin,
	input wire logic dual_interrupt_or_loss_pin_in,
	output logic dual_interrupt_or_loss_pin_out,
	output logic dual_interrupt_or_loss_pin_oe,
	// flag conditions, asynchronous
	input wire logic [FLAG_W-1:0] flagCondition,
	// status
	output cmm_pkg::cmm_status_type status,
	output logic irq
);

	localparam int FW = FLAG_W + 1;
	localparam int SW = FLAG_W + 2;
	localparam int TMAX = (INIT_CYCLES > WAKE_CYCLES) ? INIT_CYCLES : WAKE_CYCLES;
	localparam int TW = $clog2(TMAX + 1);
	localparam int RW = $clog2(`CMM_RESET_MIN_CYC + 1);
	localparam logic [TW-1:0] INIT_LAST = TW'(INIT_CYCLES - 1);
	localparam logic [TW-1:0] WAKE_LAST = TW'(WAKE_CYCLES - 1);
	localparam logic [RW-1:0] RESET_MIN = RW'(`CMM_RESET_MIN_CYC);

	generate
		if (FLAG_W < 2 || FLAG_W > 31)
		begin : gBadFlagW
			$error("FLAG_W must lie between 2 and 31");
		end
		if (INIT_CYCLES < 1 || WAKE_CYCLES < 1)
		begin : gBadTimes
			$error("INIT_CYCLES and WAKE_CYCLES must be at least one");
		end
	endgenerate

	function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] wdat,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (sel[i])
			begin
				r[8*i +: 8] = wdat[8*i +: 8];
			end
		end
		return r;
	endfunction

	// pin synchronisers: {flags, power pin, reset pin}
	logic [SW-1:0] syncA_q, syncB_q, syncC_q, stable_q;
	logic [SW-1:0] stable_d;
	logic [SW-1:0] pinRaw;
	logic resetPin, powerPin, rxLossLive;
	logic [FLAG_W-1:0] condLive;

	assign pinRaw = {flagCondition, dual_power_or_disable_pin, module_reset_n};

	always_comb
	begin
		// a change counts once second and third stage agree
		stable_d = (syncB_q & syncC_q) | (stable_q & (syncB_q | syncC_q));
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			syncA_q <= {{FLAG_W{1'b0}}, 2'b11};
			syncB_q <= {{FLAG_W{1'b0}}, 2'b11};
			syncC_q <= {{FLAG_W{1'b0}}, 2'b11};
			stable_q <= {{FLAG_W{1'b0}}, 2'b11};
		end
		else
		begin
			syncA_q <= pinRaw;
			syncB_q <= syncA_q;
			syncC_q <= syncB_q;
			stable_q <= stable_d;
		end
	end

	assign resetPin = stable_q[0];
	assign powerPin = stable_q[1];
	assign condLive = stable_q[SW-1:2];
	assign rxLossLive = condLive[`CMM_FLAG_RX_LOSS];

	// host reset pulse qualification
	logic [RW-1:0] lowCnt_q, lowCnt_d;
	logic armed_q, armed_d, resetPinPrev_q;
	logic softReset;

	always_comb
	begin
		lowCnt_d = lowCnt_q;
		armed_d = armed_q;
		softReset = 1'b0;
		if (!resetPin)
		begin
			if (lowCnt_q != RESET_MIN)
			begin
				lowCnt_d = lowCnt_q + RW'(1);
			end
			else
			begin
				armed_d = 1'b1;
			end
		end
		else
		begin
			lowCnt_d = '0;
			if (!resetPinPrev_q && armed_q)
			begin
				softReset = 1'b1;
			end
			armed_d = 1'b0;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			lowCnt_q <= '0;
			armed_q <= 1'b0;
			resetPinPrev_q <= 1'b1;
		end
		else
		begin
			lowCnt_q <= lowCnt_d;
			armed_q <= armed_d;
			resetPinPrev_q <= resetPin;
		end
	end

	// power and initialisation sequence
	cmm_pkg::cmm_state_type state_q, state_d;
	logic [TW-1:0] timer_q, timer_d;
	logic notReady_q, notReady_d;
	logic initDoneEvent;
	logic [`CMM_CTRL_W-1:0] ctrl_q, ctrl_d;
	logic pinIsDisable, lowPowerWant;

	assign pinIsDisable = ctrl_q[`CMM_CTRL_PIN_IS_DISABLE];
	// pin released high requests low power, unless it serves as transmit disable
	assign lowPowerWant = (!pinIsDisable && powerPin) || ctrl_q[`CMM_CTRL_OVERRIDE]
		|| ctrl_q[`CMM_CTRL_SOFT_LP];

	always_comb
	begin
		state_d = state_q;
		timer_d = timer_q;
		notReady_d = notReady_q;
		initDoneEvent = 1'b0;
		unique case (state_q)
			cmm_pkg::CMM_INIT:
			begin
				if (timer_q == INIT_LAST)
				begin
					timer_d = '0;
					notReady_d = 1'b0;
					initDoneEvent = 1'b1;
					state_d = lowPowerWant ? cmm_pkg::CMM_LOWPWR : cmm_pkg::CMM_ACTIVE;
				end
				else
				begin
					timer_d = timer_q + TW'(1);
				end
			end
			cmm_pkg::CMM_LOWPWR:
			begin
				if (!lowPowerWant)
				begin
					timer_d = '0;
					state_d = cmm_pkg::CMM_WAKING;
				end
			end
			cmm_pkg::CMM_WAKING:
			begin
				if (lowPowerWant)
				begin
					state_d = cmm_pkg::CMM_LOWPWR;
				end
				else if (timer_q == WAKE_LAST)
				begin
					state_d = cmm_pkg::CMM_ACTIVE;
				end
				else
				begin
					timer_d = timer_q + TW'(1);
				end
			end
			cmm_pkg::CMM_ACTIVE:
			begin
				if (lowPowerWant)
				begin
					state_d = cmm_pkg::CMM_LOWPWR;
				end
			end
		endcase
		if (softReset)
		begin
			state_d = cmm_pkg::CMM_INIT;
			timer_d = '0;
			notReady_d = 1'b1;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			state_q <= cmm_pkg::CMM_INIT;
			timer_q <= '0;
			notReady_q <= 1'b1;
		end
		else
		begin
			state_q <= state_d;
			timer_q <= timer_d;
			notReady_q <= notReady_d;
		end
	end

	// register file and flags
	logic [FW-1:0] flags_q, flags_d, mask_q, mask_d, irqEn_q, irqEn_d;
	logic ack_q, ack_d;
	logic [31:0] rdData_q, rdData_d;
	logic [31:0] statusWord;
	logic busHit, busRd, busWr;
	logic [7:0] regAdr;
	logic [FW-1:0] flagSet;

	assign busHit = wbReq.cyc && wbReq.stb && !ack_q;
	assign busRd = busHit && !wbReq.we;
	assign busWr = busHit && wbReq.we;
	assign regAdr = {wbReq.adr[7:2], 2'b00};
	// bit FLAG_W flags the end of initialisation
	assign flagSet = {initDoneEvent, condLive};

	always_comb
	begin
		statusWord = '0;
		statusWord[`CMM_ST_NOT_READY] = notReady_q;
		statusWord[`CMM_ST_INIT] = (state_q == cmm_pkg::CMM_INIT);
		statusWord[`CMM_ST_FUNCTIONAL] = (state_q == cmm_pkg::CMM_ACTIVE);
		statusWord[`CMM_ST_CLASS_ONE] = (state_q != cmm_pkg::CMM_ACTIVE);
		statusWord[`CMM_ST_TX_DISABLE] = pinIsDisable && powerPin;
		statusWord[`CMM_ST_RX_LOSS] = rxLossLive;
		statusWord[`CMM_ST_RESET_PIN] = resetPin;
	end

	always_comb
	begin
		flags_d = flags_q;
		mask_d = mask_q;
		irqEn_d = irqEn_q;
		ctrl_d = ctrl_q;
		ack_d = busHit;
		rdData_d = rdData_q;
		if (busRd)
		begin
			unique case (regAdr)
				`CMM_OFF_STATUS: rdData_d = statusWord;
				`CMM_OFF_FLAGS:
				begin
					rdData_d = 32'(flags_q);
					flags_d = '0;
				end
				`CMM_OFF_MASK: rdData_d = 32'(mask_q);
				`CMM_OFF_IRQ_EN: rdData_d = 32'(irqEn_q);
				`CMM_OFF_CTRL: rdData_d = 32'(ctrl_q);
				default: rdData_d = 32'h0000_0000;
			endcase
		end
		if (busWr)
		begin
			unique case (regAdr)
				`CMM_OFF_FLAG_CLR: flags_d = flags_q & ~FW'(wbReq.dat & {{8{wbReq.sel[3]}},
					{8{wbReq.sel[2]}}, {8{wbReq.sel[1]}}, {8{wbReq.sel[0]}}});
				`CMM_OFF_MASK: mask_d = FW'(mergeBytes(32'(mask_q), wbReq.dat, wbReq.sel));
				`CMM_OFF_IRQ_EN: irqEn_d = FW'(mergeBytes(32'(irqEn_q), wbReq.dat, wbReq.sel));
				`CMM_OFF_CTRL: ctrl_d = `CMM_CTRL_W'(mergeBytes(32'(ctrl_q), wbReq.dat, wbReq.sel));
				default:
				begin
				end
			endcase
		end
		// a condition present in the clearing cycle still sets its flag
		flags_d = flags_d | flagSet;
		if (softReset)
		begin
			flags_d = '0;
			mask_d = FW'(`CMM_MASK_RST);
			irqEn_d = FW'(`CMM_IRQ_EN_RST);
			ctrl_d = `CMM_CTRL_RST;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			flags_q <= '0;
			mask_q <= FW'(`CMM_MASK_RST);
			irqEn_q <= FW'(`CMM_IRQ_EN_RST);
			ctrl_q <= `CMM_CTRL_RST;
			ack_q <= 1'b0;
			rdData_q <= 32'h0000_0000;
		end
		else
		begin
			flags_q <= flags_d;
			mask_q <= mask_d;
			irqEn_q <= irqEn_d;
			ctrl_q <= ctrl_d;
			ack_q <= ack_d;
			rdData_q <= rdData_d;
		end
	end

	// outputs
	logic pinLow_q, pinLow_d, irq_q, irq_d;
	cmm_pkg::cmm_status_type status_q, status_d;

	always_comb
	begin
		if (ctrl_q[`CMM_CTRL_INT_IS_LOSS])
		begin
			pinLow_d = rxLossLive;
		end
		else
		begin
			pinLow_d = |(flags_q & ~mask_q);
		end
		irq_d = |(flags_q & irqEn_q);
		status_d.management_init_state = statusWord[`CMM_ST_INIT];
		status_d.fullyFunctional = statusWord[`CMM_ST_FUNCTIONAL];
		status_d.powerClassOne = statusWord[`CMM_ST_CLASS_ONE];
		status_d.transmit_disable = statusWord[`CMM_ST_TX_DISABLE];
		status_d.dataNotReady = notReady_q;
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			pinLow_q <= 1'b0;
			irq_q <= 1'b0;
			status_q <= '{management_init_state: 1'b1, fullyFunctional: 1'b0, powerClassOne: 1'b1,
				transmit_disable: 1'b0, dataNotReady: 1'b1};
		end
		else
		begin
			pinLow_q <= pinLow_d;
			irq_q <= irq_d;
			status_q <= status_d;
		end
	end

	assign wbAck = ack_q;
	assign wbDatRd = rdData_q;
	assign dual_interrupt_or_loss_pin_out = 1'b0;
	assign dual_interrupt_or_loss_pin_oe = pinLow_q;
	assign status = status_q;
	assign irq = irq_q;

endmodule // cmm_ctrl

// File: verif/cmm_ctrl_checker.sv
// assertion checker of the module management control
module cmm_ctrl_checker #(
	parameter int INIT_CYCLES = 20
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// bus
	input wire cmm_pkg::cmm_wb_req_type wbReq,
	input wire logic wbAck,
	input wire logic [31:0] wbDatRd,
	// pins and status
	input wire logic module_reset_n,
	input wire cmm_pkg::cmm_status_type status,
	input wire logic irq,
	input wire logic dual_interrupt_or_loss_pin_oe
);
	logic [15:0] lowCnt_q, lowCnt_d;
	logic [31:0] initCnt_q, initCnt_d;
	// length of host reset low, length of init
	always_comb
	begin
		lowCnt_d = module_reset_n ? 16'h0000 : lowCnt_q + {15'h0000, lowCnt_q != 16'hffff};
		initCnt_d = (status.management_init_state && module_reset_n && !reset) ? initCnt_q + 32'h1 : 32'h0;
	end
	always_ff @(posedge clk_sys)
	begin
		lowCnt_q <= lowCnt_d;
		initCnt_q <= initCnt_d;
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	property p_ackNext;
		wbReq.cyc && wbReq.stb && !wbAck |=> wbAck;
	endproperty
	a_ackNext: assert property (p_ackNext) else $error("request not answered next cycle");
	property p_ackPulse;
		wbAck |=> !wbAck;
	endproperty
	a_ackPulse: assert property (p_ackPulse) else $error("ack longer than one cycle");
	property p_datHold;
		$changed(wbDatRd) |-> wbAck;
	endproperty
	a_datHold: assert property (p_datHold) else $error("read data moved without ack");
	property p_resetVals;
		disable iff (1'b0) reset |=> !wbAck && !irq && !dual_interrupt_or_loss_pin_oe && status.management_init_state;
	endproperty
	a_resetVals: assert property (p_resetVals) else $error("outputs not at reset values");
	property p_classFunc;
		status.powerClassOne != status.fullyFunctional;
	endproperty
	a_classFunc: assert property (p_classFunc) else $error("class one and full function disagree");
	property p_shortPulse;
		$rose(module_reset_n) && lowCnt_q < 16'h04b0 && !status.management_init_state
			|=> !status.management_init_state [*8];
	endproperty
	a_shortPulse: assert property (p_shortPulse) else $error("short reset pulse restarted init");
	property p_longPulse;
		$rose(module_reset_n) && lowCnt_q > 16'h0514 |-> ##[1:8] status.management_init_state;
	endproperty
	a_longPulse: assert property (p_longPulse) else $error("long reset pulse ignored");
	property p_initBound;
		initCnt_q <= 32'(INIT_CYCLES + 8);
	endproperty
	a_initBound: assert property (p_initBound) else $error("init lasted too long");
endmodule // cmm_ctrl_checker

bind cmm_ctrl cmm_ctrl_checker #(.INIT_CYCLES(INIT_CYCLES)) u_cmm_ctrl_checker (
	.clk_sys(clk_sys), .reset(reset), .wbReq(wbReq), .wbAck(wbAck), .wbDatRd(wbDatRd),
	.module_reset_n(module_reset_n), .status(status), .irq(irq),
	.dual_interrupt_or_loss_pin_oe(dual_interrupt_or_loss_pin_oe)
);

// File: verif/cmm_host_model.sv
// host side model: reset pin, power pin and pulled-up interrupt wire
module cmm_host_model (
	// clock
	input wire logic clk_sys,
	// bench request
	input wire logic lowPowerWanted,
	// module pins
	input wire logic pinOut,
	input wire logic pinOe,
	output logic module_reset_n,
	output logic dual_power_or_disable_pin,
	output logic pinLevel
);
	timeunit 1ns;
	timeprecision 1ps;
	assign pinLevel = pinOe ? pinOut : 1'b1; // pull-up
	initial
	begin
		module_reset_n = 1'b1;
		dual_power_or_disable_pin = 1'b0;
	end
	always @(posedge clk_sys)
		dual_power_or_disable_pin <= lowPowerWanted;
	task pulse(input int n);
		@(posedge clk_sys);
		module_reset_n <= 1'b0;
		repeat (n) @(posedge clk_sys);
		module_reset_n <= 1'b1;
	endtask
endmodule // cmm_host_model

// File: verif/cmm_ctrl_tb.sv
// self-checking bench of the module management control
`include "cmm_map.svh"
module cmm_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int INIT = 20;
	localparam int WAKE = 10;
	localparam int FN = 0, C1 = 1, OE = 2, IR = 3, IN = 4, TX = 5;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	cmm_pkg::cmm_wb_req_type wbReq = '0;
	logic wbAck, irq, module_reset_n, powerPin, pinOut, pinOe, pinLevel;
	logic [31:0] wbDatRd, rd;
	logic [7:0] flagCondition = 8'h00;
	logic lowPowerWanted = 1'b0;
	cmm_pkg::cmm_status_type status;
	logic [5:0] obs;
	int miscompares = 0;
	int n_tests = 0;
	assign obs = {status.transmit_disable, status.management_init_state, irq, !pinLevel,
		status.powerClassOne, status.fullyFunctional};
	always #4 clk_sys = ~clk_sys;
	cmm_ctrl #(.INIT_CYCLES(INIT), .WAKE_CYCLES(WAKE)) u_cmm_ctrl (.clk_sys(clk_sys), .reset(reset),
		.wbReq(wbReq), .wbAck(wbAck), .wbDatRd(wbDatRd), .module_reset_n(module_reset_n),
		.dual_power_or_disable_pin(powerPin), .dual_interrupt_or_loss_pin_in(pinLevel),
		.dual_interrupt_or_loss_pin_out(pinOut), .dual_interrupt_or_loss_pin_oe(pinOe),
		.flagCondition(flagCondition), .status(status), .irq(irq));
	cmm_host_model u_cmm_host_model (.clk_sys(clk_sys), .lowPowerWanted(lowPowerWanted), .pinOut(pinOut),
		.pinOe(pinOe), .module_reset_n(module_reset_n), .dual_power_or_disable_pin(powerPin),
		.pinLevel(pinLevel));
	task automatic conclude;
		$display("comparisons %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e)
		begin
			miscompares++;
			$display("wrong value at %0t ns: saw %h, want %h", $time, s, e);
		end
	endtask
	task automatic waitObs(input int i, input logic v, input int lim);
		int n;
		n = 0;
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (obs[i] !== v && n < lim);
		chk(32'(obs[i]), 32'(v));
		if (obs[i] !== v)
			conclude();
	endtask
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		wbReq <= {2'b11, we, a, d, 4'hf};
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (wbAck !== 1'b1 && n < 50);
		rd = wbDatRd;
		wbReq.cyc <= 1'b0;
		wbReq.stb <= 1'b0;
		if (n >= 50)
		begin
			miscompares++;
			$display("wrong value at %0t ns: bus request not answered", $time);
			conclude();
		end
	endtask
	task automatic rdk(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	task automatic tInit;
		waitObs(IN, 0, INIT + 10);
		waitObs(FN, 1, 10);
		waitObs(OE, 1, 10);
		chk(32'(status.dataNotReady), 32'h0);
		rdk(`CMM_OFF_STATUS, 32'h44);
		rdk(`CMM_OFF_FLAGS, 32'h100);
		waitObs(OE, 0, 70);
		rdk(`CMM_OFF_MASK, 32'h0);
		rdk(`CMM_OFF_IRQ_EN, 32'h0);
		rdk(`CMM_OFF_CTRL, 32'h0);
		rdk(8'h40, 32'h0);
		wb(1'b1, `CMM_OFF_MASK, 32'h5a);
		rdk(`CMM_OFF_MASK, 32'h5a);
		wb(1'b1, `CMM_OFF_MASK, 32'h0);
		$display("init test done");
	endtask
	task automatic tFlags;
		for (int b = 0; b < 2; b++)
		begin
			flagCondition <= 8'(1 << b);
			waitObs(OE, 1, 20);
			flagCondition <= 8'h00;
			repeat (8) @(posedge clk_sys);
			rdk(`CMM_OFF_FLAGS, 32'(1 << b));
			waitObs(OE, 0, 70);
			rdk(`CMM_OFF_FLAGS, 32'h0);
		end
		$display("flag test done");
	endtask
	task automatic tMask;
		flagCondition <= 8'h04;
		waitObs(OE, 1, 20);
		wb(1'b1, `CMM_OFF_MASK, 32'h4);
		waitObs(OE, 0, 4);
		wb(1'b1, `CMM_OFF_MASK, 32'h0);
		waitObs(OE, 1, 4);
		wb(1'b1, `CMM_OFF_IRQ_EN, 32'h4);
		waitObs(IR, 1, 4);
		flagCondition <= 8'h00;
		repeat (8) @(posedge clk_sys);
		wb(1'b1, `CMM_OFF_FLAG_CLR, 32'h4);
		waitObs(IR, 0, 4);
		waitObs(OE, 0, 70);
		wb(1'b1, `CMM_OFF_IRQ_EN, 32'h0);
		$display("mask test done");
	endtask
	task automatic tPower;
		lowPowerWanted <= 1'b1;
		waitObs(C1, 1, 10);
		lowPowerWanted <= 1'b0;
		waitObs(FN, 1, WAKE + 10);
		for (int c = 1; c < 3; c++)
		begin
			wb(1'b1, `CMM_OFF_CTRL, 32'(c));
			waitObs(C1, 1, 10);
			wb(1'b1, `CMM_OFF_CTRL, 32'h0);
			waitObs(FN, 1, WAKE + 10);
		end
		wb(1'b1, `CMM_OFF_CTRL, 32'h4);
		lowPowerWanted <= 1'b1;
		waitObs(TX, 1, 10);
		chk(32'(status.fullyFunctional), 32'h1);
		lowPowerWanted <= 1'b0;
		waitObs(TX, 0, 10);
		wb(1'b1, `CMM_OFF_CTRL, 32'h0);
		$display("power test done");
	endtask
	task automatic tLoss;
		wb(1'b1, `CMM_OFF_CTRL, 32'h8);
		flagCondition <= 8'h01;
		waitObs(OE, 1, 20);
		flagCondition <= 8'h00;
		waitObs(OE, 0, 20);
		wb(1'b1, `CMM_OFF_CTRL, 32'h0);
		waitObs(OE, 1, 10);
		rdk(`CMM_OFF_FLAGS, 32'h1);
		waitObs(OE, 0, 70);
		$display("loss test done");
	endtask
	task automatic tPinReset;
		u_cmm_host_model.pulse(100);
		repeat (10) @(posedge clk_sys);
		chk(32'(status.management_init_state), 32'h0);
		wb(1'b1, `CMM_OFF_MASK, 32'h3);
		u_cmm_host_model.pulse(1400);
		waitObs(IN, 1, 10);
		chk(32'(status.dataNotReady), 32'h1);
		waitObs(IN, 0, INIT + 10);
		waitObs(FN, 1, 10);
		chk(32'(status.dataNotReady), 32'h0);
		rdk(`CMM_OFF_MASK, 32'h0);
		rdk(`CMM_OFF_FLAGS, 32'h100);
		$display("pin reset test done");
	endtask
	initial
	begin
		repeat (12) @(posedge clk_sys);
		reset <= 1'b0;
		tInit();
		tFlags();
		tMask();
		tPower();
		tLoss();
		tPinReset();
		conclude();
	end
endmodule // cmm_ctrl_tb
